// File: verilog/vfts_scanout.sv
// Frame and text scan-out engine with double-buffered frame pointers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "vfts_map.svh"

// Operation
// [R01] Visible raster is 640 by 480
// [R02] Frame is 320x240, origin upper-left
// [R03] Each stored pixel fills 2x2 screen block
// [R04] Pixel word is RGB 5-6-5
// [R05] XY address is base, row<<10, col<<1
// [R06] Fetch pixels sequentially every frame
// [R07] Processor writes never block the display
// [R08] Front pointer shows frame, resets C8000000
// [R09] Back pointer writable, same reset
// [R10] Fetch only SDRAM or on-chip region
// [R11] Writing 1 to front requests swap
// [R12] Swap deferred to vertical sync
// [R13] Pending bit set on request, cleared after
// [R14] Software polls pending before drawing back
// [R15] Status reports X and Y bits
// [R16] Status reports bytes per pixel
// [R17] Status reports addressing mode
// [R18] Resolution register reports frame size
// [R19] Text is 80x60 cells of 8x8
// [R20] Cells hold ASCII, drawn by font table
// [R21] Text address is base, row<<7, col
// [R22] Glyph pixels show text colour
// [R23] Sync and blanking for 640x480 at 60
module vfts_scanout #(
    parameter int XBITS     = `VFTS_XBITS,
    parameter int YBITS     = `VFTS_YBITS,
    parameter int BPP       = `VFTS_BPP,
    parameter int ADDR_MODE = `VFTS_ADDR_MODE,
    parameter int RES_X     = `VFTS_FRAME_X,
    parameter int RES_Y     = `VFTS_FRAME_Y
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   srst_i,
    input  wire logic [31:0]            addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    output vfts_pkg::vfts_mem_req_t     mem_o,
    input  wire logic [15:0]            mem_rdata_i,
    output vfts_pkg::vfts_vga_t         vga_o
);

    localparam logic [9:0]  H_TOTAL  = `VFTS_H_VIS + `VFTS_H_FP + `VFTS_H_SYNC + `VFTS_H_BP;
    localparam logic [9:0]  V_TOTAL  = `VFTS_V_VIS + `VFTS_V_FP + `VFTS_V_SYNC + `VFTS_V_BP;
    localparam logic [9:0]  HS_START = `VFTS_H_VIS + `VFTS_H_FP;
    localparam logic [9:0]  HS_END   = HS_START + `VFTS_H_SYNC;
    localparam logic [9:0]  VS_START = `VFTS_V_VIS + `VFTS_V_FP;
    localparam logic [9:0]  VS_END   = VS_START + `VFTS_V_SYNC;
    localparam int          PIX_STEP_I = (`VFTS_PIX_CLK_KHZ * (1 << `VFTS_PIX_ACC_BITS))
                                         / `VFTS_SYS_CLK_KHZ;
    localparam logic [`VFTS_PIX_ACC_BITS:0] PIX_STEP = (`VFTS_PIX_ACC_BITS+1)'(PIX_STEP_I);
    localparam int          TXT_DEPTH = `VFTS_TXT_ROWS << `VFTS_TEXT_ROW_SHIFT;
    localparam logic [31:0] BPP_W     = 32'(BPP);
    localparam logic [31:0] RES_X_W   = 32'(RES_X);

    logic [31:0]                  front_ptr;
    logic [31:0]                  back_ptr;
    logic                         swap_pending;
    logic [15:0]                  text_color;
    logic [`VFTS_PIX_ACC_BITS-1:0] pix_acc;
    logic                         pix_en;
    logic [9:0]                   h_cnt;
    logic [9:0]                   v_cnt;
    logic [7:0]                   txt_mem [0:TXT_DEPTH-1];

    logic                         rd_q;
    logic [15:0]                  pix_word;
    logic [15:0]                  pix_hold;
    logic [XBITS-1:0]             fetch_x_q;
    logic [YBITS-1:0]             fetch_y_q;

    logic [7:0]                   ch_b;
    logic [5:0]                   sub_b;
    logic                         vis_b;
    logic                         hs_b;
    logic                         vs_b;
    logic                         odd_b;
    logic                         glyph_c;
    logic                         vis_c;
    logic                         hs_c;
    logic                         vs_c;
    logic                         odd_c;

    logic                         vis_a;
    logic                         hs_a;
    logic                         vs_a;
    logic                         swap_evt;
    logic                         swap_req;
    logic                         reach_ok;
    logic                         txt_hit;
    logic [XBITS-1:0]             fx;
    logic [YBITS-1:0]             fy;
    logic [31:0]                  fetch_off;
    logic [`VFTS_PIX_ACC_BITS:0]  next_acc;
    logic [15:0]                  pix_now;
    logic [63:0]                  glyph_row;
    logic [31:0]                  status_word;
    logic [31:0]                  last_rd_addr;

    // Built-in font: digits, upper case (lower case folds onto it), a few marks
    function automatic logic [63:0] vfts_glyph(input logic [7:0] code);
        logic [7:0]  c;
        logic [63:0] g;
        c = (code >= 8'h61 && code <= 8'h7A) ? code - 8'h20 : code;
        unique case (c)
            8'h30:   g = 64'h3C66_6E76_6666_3C00;
            8'h31:   g = 64'h1838_1818_1818_7E00;
            8'h32:   g = 64'h3C66_060C_3060_7E00;
            8'h33:   g = 64'h3C66_061C_0666_3C00;
            8'h34:   g = 64'h0C1C_3C6C_7E0C_0C00;
            8'h35:   g = 64'h7E60_7C06_0666_3C00;
            8'h36:   g = 64'h3C60_7C66_6666_3C00;
            8'h37:   g = 64'h7E06_0C18_3030_3000;
            8'h38:   g = 64'h3C66_663C_6666_3C00;
            8'h39:   g = 64'h3C66_663E_060C_3800;
            8'h41:   g = 64'h183C_6666_7E66_6600;
            8'h42:   g = 64'h7C66_667C_6666_7C00;
            8'h43:   g = 64'h3C66_6060_6066_3C00;
            8'h44:   g = 64'h786C_6666_666C_7800;
            8'h45:   g = 64'h7E60_607C_6060_7E00;
            8'h46:   g = 64'h7E60_607C_6060_6000;
            8'h47:   g = 64'h3C66_606E_6666_3C00;
            8'h48:   g = 64'h6666_667E_6666_6600;
            8'h49:   g = 64'h3C18_1818_1818_3C00;
            8'h4A:   g = 64'h1E0C_0C0C_0C6C_3800;
            8'h4B:   g = 64'h666C_7870_786C_6600;
            8'h4C:   g = 64'h6060_6060_6060_7E00;
            8'h4D:   g = 64'h6377_7F6B_6363_6300;
            8'h4E:   g = 64'h6676_7E7E_6E66_6600;
            8'h4F:   g = 64'h3C66_6666_6666_3C00;
            8'h50:   g = 64'h7C66_667C_6060_6000;
            8'h51:   g = 64'h3C66_6666_663C_0E00;
            8'h52:   g = 64'h7C66_667C_786C_6600;
            8'h53:   g = 64'h3C66_603C_0666_3C00;
            8'h54:   g = 64'h7E18_1818_1818_1800;
            8'h55:   g = 64'h6666_6666_6666_3C00;
            8'h56:   g = 64'h6666_6666_663C_1800;
            8'h57:   g = 64'h6363_636B_7F77_6300;
            8'h58:   g = 64'h6666_3C18_3C66_6600;
            8'h59:   g = 64'h6666_663C_1818_1800;
            8'h5A:   g = 64'h7E06_0C18_3060_7E00;
            8'h2D:   g = 64'h0000_007E_0000_0000;
            8'h2E:   g = 64'h0000_0000_0018_1800;
            8'h3A:   g = 64'h0018_1800_1818_0000;
            default: g = 64'h0000_0000_0000_0000;
        endcase
        return g;
    endfunction

    // [R23] pixel rate enable
    assign next_acc = {1'b0, pix_acc} + PIX_STEP;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pix_acc <= '0;
            pix_en  <= 1'b0;
        end else begin
            pix_acc <= next_acc[`VFTS_PIX_ACC_BITS-1:0];
            pix_en  <= next_acc[`VFTS_PIX_ACC_BITS];
        end
    end

    // [R01] raster counters
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            h_cnt <= '0;
            v_cnt <= '0;
        end else if (pix_en) begin
            if (h_cnt == H_TOTAL - 10'h001) begin
                h_cnt <= '0;
                v_cnt <= (v_cnt == V_TOTAL - 10'h001) ? 10'h000 : v_cnt + 10'h001;
            end else begin
                h_cnt <= h_cnt + 10'h001;
            end
        end
    end

    // [R23] sync windows, active low
    assign vis_a = (h_cnt < `VFTS_H_VIS) && (v_cnt < `VFTS_V_VIS);
    assign hs_a  = !((h_cnt >= HS_START) && (h_cnt < HS_END));
    assign vs_a  = !((v_cnt >= VS_START) && (v_cnt < VS_END));

    // [R12] swap point: end of last front-porch line, just before vertical sync
    assign swap_evt = pix_en && (h_cnt == H_TOTAL - 10'h001) && (v_cnt == VS_START - 10'h001);
    // [R11] swap command decode
    assign swap_req = wr_i && (addr_i == `VFTS_FRONT_ADDR) && (wdata_i == `VFTS_SWAP_CMD);

    // [R08] front pointer, only moved by a swap
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            front_ptr <= `VFTS_FRAME_RST;
        end else if (swap_evt && swap_pending) begin
            front_ptr <= back_ptr;
        end
    end

    // [R09] back pointer, a bus write wins over the swap
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            back_ptr <= `VFTS_FRAME_RST;
        end else if (wr_i && addr_i == `VFTS_BACK_ADDR) begin
            back_ptr <= wdata_i;
        end else if (swap_evt && swap_pending) begin
            back_ptr <= front_ptr;
        end
    end

    // [R13] pending flag, a new request wins over completion
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            swap_pending <= 1'b0;
        end else if (swap_req) begin
            swap_pending <= 1'b1;
        end else if (swap_evt) begin
            swap_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            text_color <= `VFTS_TXTCOL_RST;
        end else if (wr_i && addr_i == `VFTS_TXTCOL_ADDR) begin
            text_color <= wdata_i[15:0];
        end
    end

    // [R21] text cell writes at base plus row<<7 plus column
    assign txt_hit = (addr_i[31:`VFTS_TEXT_ABITS]
                      == (32-`VFTS_TEXT_ABITS)'(`VFTS_TEXT_BASE >> `VFTS_TEXT_ABITS))
                     && (32'(addr_i[`VFTS_TEXT_ABITS-1:0]) < 32'(TXT_DEPTH));

    always_ff @(posedge sys_clk_i) begin
        if (wr_i && txt_hit) begin
            txt_mem[addr_i[`VFTS_TEXT_ABITS-1:0]] <= wdata_i[7:0];
        end
    end

    // [R15] [R16] [R17] status fields
    always_comb begin
        status_word = '0;
        status_word[`VFTS_ST_SWAP] = swap_pending;
        status_word[`VFTS_ST_MODE] = ADDR_MODE[0];
        status_word[`VFTS_ST_BPP_LSB +: 4]   = 4'(BPP);
        status_word[`VFTS_ST_XBITS_LSB +: 4] = 4'(XBITS);
        status_word[`VFTS_ST_YBITS_LSB +: 4] = 4'(YBITS);
    end

    // [R18] register reads, data stands while rd_i is held, cleared the cycle after
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !rd_i) begin
            rdata_o <= '0;
        end else if (txt_hit) begin
            rdata_o <= {24'h00_0000, txt_mem[addr_i[`VFTS_TEXT_ABITS-1:0]]};
        end else begin
            unique case (addr_i)
                `VFTS_FRONT_ADDR:  rdata_o <= front_ptr;
                `VFTS_BACK_ADDR:   rdata_o <= back_ptr;
                `VFTS_RES_ADDR:    rdata_o <= {16'(RES_Y), 16'(RES_X)};
                `VFTS_STATUS_ADDR: rdata_o <= status_word;
                `VFTS_TXTCOL_ADDR: rdata_o <= {16'h0000, text_color};
                default:           rdata_o <= '0;
            endcase
        end
    end

    // [R02] [R03] stored coordinate is screen coordinate halved
    assign fx = h_cnt[XBITS:1];
    assign fy = v_cnt[YBITS:1];

    // [R05] [R17] pixel offset per addressing mode
    always_comb begin
        if (ADDR_MODE == 0) begin
            fetch_off = ((32'(fy) << XBITS) | 32'(fx)) * BPP_W;
        end else begin
            fetch_off = (32'(fy) * RES_X_W + 32'(fx)) * BPP_W;
        end
    end

    // [R10] reachable memory windows
    assign reach_ok = ((front_ptr & `VFTS_SDRAM_MASK) == `VFTS_SDRAM_BASE)
                   || ((front_ptr & `VFTS_ONCHIP_MASK) == `VFTS_ONCHIP_BASE);

    // [R06] [R07] read-only master, one read per stored pixel on each line
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mem_o     <= '0;
            fetch_x_q <= '0;
            fetch_y_q <= '0;
        end else begin
            mem_o.rd <= pix_en && vis_a && !h_cnt[0] && reach_ok;
            if (pix_en && vis_a && !h_cnt[0]) begin
                mem_o.addr <= front_ptr + fetch_off;
                fetch_x_q  <= fx;
                fetch_y_q  <= fy;
            end
        end
    end

    // [R04] capture the 5-6-5 word, black when unreachable
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_q     <= 1'b0;
            pix_word <= '0;
        end else begin
            rd_q <= mem_o.rd;
            if (rd_q) begin
                pix_word <= mem_rdata_i;
            end else if (pix_en && vis_a && !h_cnt[0] && !reach_ok) begin
                pix_word <= '0;
            end
        end
    end

    // [R19] [R20] cell lookup from 8x8 position
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ch_b  <= '0;
            sub_b <= '0;
            vis_b <= 1'b0;
            hs_b  <= 1'b1;
            vs_b  <= 1'b1;
            odd_b <= 1'b0;
        end else if (pix_en) begin
            ch_b  <= vis_a ? txt_mem[{v_cnt[8:`VFTS_CELL_BITS], h_cnt[9:`VFTS_CELL_BITS]}]
                           : 8'h00;
            sub_b <= {v_cnt[`VFTS_CELL_BITS-1:0], h_cnt[`VFTS_CELL_BITS-1:0]};
            vis_b <= vis_a;
            hs_b  <= hs_a;
            vs_b  <= vs_a;
            odd_b <= h_cnt[0];
        end
    end

    // [R20] glyph bit from the font table
    assign glyph_row = vfts_glyph(ch_b);

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            glyph_c <= 1'b0;
            vis_c   <= 1'b0;
            hs_c    <= 1'b1;
            vs_c    <= 1'b1;
            odd_c   <= 1'b0;
        end else if (pix_en) begin
            glyph_c <= glyph_row[~sub_b];
            vis_c   <= vis_b;
            hs_c    <= hs_b;
            vs_c    <= vs_b;
            odd_c   <= odd_b;
        end
    end

    // [R03] odd column repeats the held even pixel
    assign pix_now = odd_c ? pix_hold : pix_word;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pix_hold <= '0;
        end else if (pix_en && !odd_c) begin
            pix_hold <= pix_word;
        end
    end

    // [R22] text over frame, black in blanking
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            vga_o <= '{hsync_n: 1'b1, vsync_n: 1'b1, de: 1'b0, rgb: '0};
        end else if (pix_en) begin
            vga_o.hsync_n <= hs_c;
            vga_o.vsync_n <= vs_c;
            vga_o.de      <= vis_c;
            if (!vis_c) begin
                vga_o.rgb <= '0;
            end else if (glyph_c) begin
                vga_o.rgb <= text_color;
            end else begin
                vga_o.rgb <= pix_now;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            last_rd_addr <= '0;
        end else if (mem_o.rd) begin
            last_rd_addr <= mem_o.addr;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_swap_exchange: assert property (swap_evt && swap_pending |=> front_ptr == $past(back_ptr)) // [R12]
        else $error("front pointer did not take back pointer at swap");
    a_pend_set: assert property (swap_req |=> swap_pending) // [R13]
        else $error("swap request did not set pending");
    a_pend_clear: assert property (swap_pending && swap_evt && !swap_req |=> !swap_pending) // [R13]
        else $error("pending not cleared after swap");
    a_pend_vsync: assert property ($fell(swap_pending) |-> $past(swap_evt)) // [R12]
        else $error("pending cleared away from vertical sync");
    a_fetch_seq: assert property (mem_o.rd && fetch_x_q != '0 |-> mem_o.addr == last_rd_addr + BPP_W) // [R06]
        else $error("pixel fetch not sequential");
    a_fetch_row: assert property (mem_o.rd && fetch_x_q == '0 && ADDR_MODE == 0 |->
        mem_o.addr == front_ptr + ((32'(fetch_y_q) << XBITS) * BPP_W)) // [R05]
        else $error("row start address wrong");
    a_status_read: assert property (rd_i && addr_i == `VFTS_STATUS_ADDR |=>
        rdata_o[`VFTS_ST_SWAP] == $past(swap_pending) && rdata_o[`VFTS_ST_BPP_LSB +: 4] == 4'(BPP)) // [R16]
        else $error("status read mismatch");
    a_res_read: assert property (rd_i && addr_i == `VFTS_RES_ADDR |=>
        rdata_o == {16'(RES_Y), 16'(RES_X)}) // [R18]
        else $error("resolution read mismatch");
    a_blank_black: assert property (!vga_o.de |-> vga_o.rgb == '0) // [R23]
        else $error("colour driven in blanking");

endmodule // vfts_scanout

// File: verilog/vfts_map.svh
// Address map, field positions, reset values and timing counts of the scan-out block
`ifndef VFTS_MAP_SVH
`define VFTS_MAP_SVH

`define VFTS_FRONT_ADDR     32'hFF20_3020
`define VFTS_BACK_ADDR      32'hFF20_3024
`define VFTS_RES_ADDR       32'hFF20_3028
`define VFTS_STATUS_ADDR    32'hFF20_302C
`define VFTS_TXTCOL_ADDR    32'hFF20_3030
`define VFTS_TEXT_BASE      32'hC900_0000
`define VFTS_TEXT_ABITS     13
`define VFTS_TEXT_ROW_SHIFT 7

`define VFTS_FRAME_RST      32'hC800_0000
`define VFTS_SWAP_CMD       32'h0000_0001
`define VFTS_TXTCOL_RST     16'hFFFF
`define VFTS_SDRAM_BASE     32'hC000_0000
`define VFTS_SDRAM_MASK     32'hFC00_0000
`define VFTS_ONCHIP_BASE    32'hC800_0000
`define VFTS_ONCHIP_MASK    32'hFF00_0000

`define VFTS_ST_SWAP        0
`define VFTS_ST_MODE        1
`define VFTS_ST_BPP_LSB     4
`define VFTS_ST_XBITS_LSB   24
`define VFTS_ST_YBITS_LSB   28
`define VFTS_RES_Y_LSB      16

`define VFTS_FRAME_X        320
`define VFTS_FRAME_Y        240
`define VFTS_XBITS          9
`define VFTS_YBITS          8
`define VFTS_BPP            2
`define VFTS_ADDR_MODE      0
`define VFTS_TXT_COLS       80
`define VFTS_TXT_ROWS       60
`define VFTS_CELL_BITS      3

`define VFTS_H_VIS          10'h280
`define VFTS_H_FP           10'h010
`define VFTS_H_SYNC         10'h060
`define VFTS_H_BP           10'h030
`define VFTS_V_VIS          10'h1E0
`define VFTS_V_FP           10'h00A
`define VFTS_V_SYNC         10'h002
`define VFTS_V_BP           10'h021

`define VFTS_SYS_CLK_KHZ    40000
`define VFTS_PIX_CLK_KHZ    25000
`define VFTS_PIX_ACC_BITS   3

`endif

// File: verilog/vfts_pkg.sv
// Types shared by the frame and text scan-out block
package vfts_pkg;

    typedef struct packed {
        logic [4:0] red;
        logic [5:0] green;
        logic [4:0] blue;
    } vfts_rgb_t;

    typedef struct packed {
        logic      hsync_n;
        logic      vsync_n;
        logic      de;
        vfts_rgb_t rgb;
    } vfts_vga_t;

    typedef struct packed {
        logic        rd;
        logic [31:0] addr;
    } vfts_mem_req_t;

endpackage

// File: tb/vfts_mem_model.sv
// Frame memory model that answers scan-out reads one cycle after the request
`timescale 1ns/1ps
module vfts_mem_model (
    input  wire logic                    sys_clk_i,
    input  wire logic                    srst_i,
    input  wire vfts_pkg::vfts_mem_req_t mem_i,
    output logic [15:0]                  mem_rdata_o
);
    // Word encodes its own address
    // Between fetches the bus toggles so that stale data never looks valid
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mem_rdata_o <= 16'h0000;
        end else if (mem_i.rd) begin
            mem_rdata_o <= mem_i.addr[16:1];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule // vfts_mem_model

// File: tb/tb.sv
// Self-checking bench for the frame and text scan-out block
`timescale 1ns/1ps
module tb;
    localparam int LINES = 24;
    logic                    sys_clk_i = 1'b0;
    logic                    srst_i    = 1'b1;
    logic [31:0]             addr_i    = 32'h0000_0000;
    logic [31:0]             wdata_i   = 32'h0000_0000;
    logic                    wr_i      = 1'b0;
    logic                    rd_i      = 1'b0;
    logic [31:0]             rdata_o;
    vfts_pkg::vfts_mem_req_t mem_o;
    logic [15:0]             mem_rdata_i;
    vfts_pkg::vfts_vga_t     vga_o;
    logic [31:0]             lfsr      = 32'h0000_eb57;
    logic [15:0]             txt_col   = 16'hFE00;
    logic [31:0]             fa;
    logic [8:0]              prev_x    = 9'h1FF;
    logic                    prev_de   = 1'b0;
    logic                    prev_hs   = 1'b1;
    int                      err_total = 0;
    int                      checked   = 0;
    int                      line      = 0;
    int                      de_len    = 0;
    int                      runs      = 0;
    int                      nrd       = 0;
    int                      txt_hits  = 0;
    int                      hs_falls  = 0;

    vfts_scanout vfts_scanout_inst (
        .sys_clk_i  (sys_clk_i),
        .srst_i     (srst_i),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .rdata_o    (rdata_o),
        .mem_o      (mem_o),
        .mem_rdata_i(mem_rdata_i),
        .vga_o      (vga_o)
    );
    vfts_mem_model vfts_mem_model_inst (
        .sys_clk_i  (sys_clk_i),
        .srst_i     (srst_i),
        .mem_i      (mem_o),
        .mem_rdata_o(mem_rdata_i)
    );

    always #12.5 sys_clk_i = ~sys_clk_i;

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] status_exp(input logic pend);
        return 32'h8900_0020 | {31'h0000_0000, pend};
    endfunction
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe, dropped at the edge that takes the write
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        rd_i    <= 1'b0;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd_cmp(input string what, input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        wr_i   <= 1'b0;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        cmp(what, exp, rdata_o);
    endtask
    task automatic final_report();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Fetch order and screen raster watch
    always @(posedge sys_clk_i) begin
        if (!srst_i) begin
            if (mem_o.rd && nrd < 320 * LINES) begin
                fa = 32'hC800_0000 + 32'((nrd / 640) * 1024 + (nrd % 320) * 2);
                cmp("fetch address", fa, mem_o.addr);
                nrd++;
            end
            if (vga_o.de) begin
                de_len++;
                if (line >= 16 && vga_o.rgb === txt_col) begin
                    txt_hits++;
                end else if (line >= 2) begin
                    cmp("pixel row", 32'(line / 2), 32'(vga_o.rgb[15:9]));
                    runs = runs + ((vga_o.rgb[8:0] !== prev_x) ? 1 : 0);
                    prev_x = vga_o.rgb[8:0];
                end
            end
            if (prev_de && !vga_o.de) begin
                if (line >= 2 && line < 16) begin
                    cmp("pixels per line", 32'h0000_0140, 32'(runs));
                    cmp("last column", 32'h0000_013F, {23'h0, prev_x});
                end
                cmp("active cycles", 32'h0000_0400, 32'(de_len));
                cmp("hsync pulses", 32'(line), 32'(hs_falls));
                cmp("vsync idle", 32'h0000_0001, {31'h0, vga_o.vsync_n});
                line++;
                de_len = 0;
                runs = 0;
                prev_x = 9'h1FF;
            end
            if (prev_hs && !vga_o.hsync_n) hs_falls++;
            prev_de = vga_o.de;
            prev_hs = vga_o.hsync_n;
        end
    end

    initial begin
        logic [31:0] back;
        int rr;
        int cc;
        repeat (16) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd_cmp("front", 32'hFF20_3020, 32'hC800_0000);
        rd_cmp("back", 32'hFF20_3024, 32'hC800_0000);
        rd_cmp("status", 32'hFF20_302C, status_exp(1'b0));
        rd_cmp("resolution", 32'hFF20_3028, 32'h00F0_0140);
        rd_cmp("unmapped", 32'hFF20_3034, 32'h0000_0000);
        lfsr = next_rand(lfsr);
        txt_col = {7'h7F, lfsr[8:0]};
        bus_wr(32'hFF20_3030, {16'h0000, txt_col});
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 80; c++) begin
                bus_wr(32'hC900_0000 + 32'(r * 128 + c), (r == 2) ? 32'h48 : 32'h20);
            end
        end
        rd_cmp("text colour", 32'hFF20_3030, {16'h0000, txt_col});
        bus_wr(32'hC900_1DFF, 32'h0000_005A);
        bus_wr(32'hC900_1DCF, 32'h0000_0031);
        rd_cmp("text 127,59", 32'hC900_1DFF, 32'h0000_005A);
        rd_cmp("text 79,59", 32'hC900_1DCF, 32'h0000_0031);
        for (int i = 0; i < 6; i++) begin
            lfsr = next_rand(lfsr);
            rr = lfsr[9:8] % 3;
            cc = lfsr[6:0] % 80;
            rd_cmp("text cell", 32'hC900_0000 + 32'(rr * 128 + cc), (rr == 2) ? 32'h48 : 32'h20);
        end
        lfsr = next_rand(lfsr);
        back = lfsr;
        bus_wr(32'hFF20_3024, back);
        bus_wr(32'hFF20_3020, lfsr | 32'h0000_0002);
        bus_wr(32'hFF20_302C, 32'hFFFF_FFFF);
        rd_cmp("back", 32'hFF20_3024, back);
        rd_cmp("front kept", 32'hFF20_3020, 32'hC800_0000);
        rd_cmp("status kept", 32'hFF20_302C, status_exp(1'b0));
        bus_wr(32'hFF20_3020, 32'h0000_0001);
        rd_cmp("pending", 32'hFF20_302C, status_exp(1'b1));
        rd_cmp("front deferred", 32'hFF20_3020, 32'hC800_0000);
        rd_cmp("back deferred", 32'hFF20_3024, back);
        while (line < LINES) @(posedge sys_clk_i);
        rd_cmp("pending held", 32'hFF20_302C, status_exp(1'b1));
        cmp("text pixels", 32'h0000_0001, 32'(txt_hits > 0));
        final_report();
    end

    // Watchdog sized at about twice the expected run
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        err_total++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        final_report();
    end
endmodule // tb
